// ### design/wwdt_pkg.sv
// Package for the windowed watchdog: addresses, codes, option-byte fields,
// carrier structs and the state enumeration.
// Assumes one 125 MHz system clock and a CPU that flags bit-level accesses.
package wwdt_pkg;

    // Kick register and its fixed values
    localparam logic [15:0] WWDT_KICK_ADDR = 16'hFF99;
    localparam logic [7:0] WWDT_SERVICE_CODE = 8'hAC;
    localparam logic [7:0] WWDT_KICK_RST_ON = 8'h9A;
    localparam logic [7:0] WWDT_KICK_RST_OFF = 8'h1A;

    // Address where the option byte lives in the memory map
    localparam logic [15:0] WWDT_OPTION_ADDR = 16'h0080;
    // Lower end of the range exempt from data-access checking (up to top of space)
    localparam logic [15:0] WWDT_EXEMPT_LO = 16'hFB00;

    // Option-byte field positions
    localparam int WWDT_OPT_WIN_HI = 6;
    localparam int WWDT_OPT_WIN_LO = 5;
    localparam int WWDT_OPT_EN_BIT = 4;
    localparam int WWDT_OPT_OVF_HI = 3;
    localparam int WWDT_OPT_OVF_LO = 1;

    // Watchdog cause position in the reset cause register
    localparam int WWDT_CAUSE_BIT = 4;

    // Counter width, enough for the longest period of 2^17 ticks
    localparam int WWDT_CNT_W = 18;
    localparam logic [WWDT_CNT_W-1:0] WWDT_CNT_ZERO = 18'h0_0000;
    localparam logic [WWDT_CNT_W-1:0] WWDT_CNT_ONE = 18'h0_0001;

    // Reset values
    localparam logic [7:0] WWDT_RDATA_RST = 8'h00;
    localparam logic [7:0] WWDT_CAUSE_RST = 8'h00;

    // Overflow exponents for select codes 0 to 7
    localparam logic [4:0] WWDT_EXP_0 = 5'h07;
    localparam logic [4:0] WWDT_EXP_1 = 5'h08;
    localparam logic [4:0] WWDT_EXP_2 = 5'h09;
    localparam logic [4:0] WWDT_EXP_3 = 5'h0A;
    localparam logic [4:0] WWDT_EXP_4 = 5'h0C;
    localparam logic [4:0] WWDT_EXP_5 = 5'h0E;
    localparam logic [4:0] WWDT_EXP_6 = 5'h0F;
    localparam logic [4:0] WWDT_EXP_7 = 5'h11;
    localparam logic [4:0] WWDT_QUARTER_SHIFT = 5'h02;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic fetch;
        logic bitop;
    } wwdt_bus_req_type;

    typedef struct packed {
        logic [15:0] rom_top;
        logic [15:0] ram_base;
    } wwdt_mem_map_type;

    typedef struct packed {
        logic enable;
        logic window_select_hi;
        logic window_select_lo;
        logic [2:0] overflow_select;
    } wwdt_cfg_type;

    localparam wwdt_cfg_type WWDT_CFG_RST = '{1'b0, 1'b0, 1'b0, 3'h0};

    typedef enum logic [1:0] {
        WWDT_ST_LOAD,
        WWDT_ST_RUN,
        WWDT_ST_OFF
    } wwdt_state_type;

endpackage

// ### design/wwdt_tick_sync.sv
// Two-stage synchroniser with rising-edge detector for the low-speed clock.
// Assumes the low-speed clock is far slower than clk, so no edge is missed.
module wwdt_tick_sync
    import wwdt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Asynchronous clock from the oscillator
    input wire logic async_in,
    // One-cycle pulse per rising edge
    output logic tick
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_prev;

    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // Only the second stage feeds the edge detector
    assign tick = sync_ff & ~prev_ff;

endmodule // wwdt_tick_sync

// ### design/wwdt_top.sv
// Windowed watchdog: counter, window check, kick register, access checks.
// Assumes the CPU presents one access per cycle on bus_req and flags
// bit-level instructions; option byte is stable when reset is released.

module wwdt_top
    import wwdt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Low-speed oscillator clock
    input wire logic lsosc_clk,
    // Option byte contents
    input wire logic [7:0] option_byte,
    // CPU access
    input wire wwdt_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    // Enabled memory area
    input wire wwdt_mem_map_type memory_size_select,
    // Reset generation and cause
    output logic internal_reset,
    input wire logic cause_clear,
    output logic watchdog_cause_flag,
    output logic [7:0] reset_cause_register,
    // Status
    output logic counting,
    output logic window_open,
    output logic [WWDT_CNT_W-1:0] count_value
);

    logic tick;
    wwdt_state_type state_ff;
    wwdt_state_type nxt_state;
    wwdt_cfg_type cfg_ff;
    wwdt_cfg_type nxt_cfg;
    logic [WWDT_CNT_W-1:0] cnt_ff;
    logic [WWDT_CNT_W-1:0] nxt_cnt;
    logic first_done_ff;
    logic nxt_first_done;
    logic kick_pend_ff;
    logic nxt_kick_pend;
    logic [7:0] kick_val_ff;
    logic [7:0] nxt_kick_val;
    logic rst_ff;
    logic nxt_rst;
    logic cause_ff;
    logic nxt_cause;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    logic [4:0] exp_sel;
    logic [WWDT_CNT_W-1:0] period_m1;
    logic [WWDT_CNT_W-1:0] quarter;
    logic [WWDT_CNT_W-1:0] closed_lim;
    logic closed;
    logic running;
    logic kick_wr;
    logic kick_bad;
    logic kick_ok;
    logic outside;
    logic fetch_bad;
    logic data_bad;
    logic overflow;
    logic fault;

    wwdt_tick_sync u_tick_sync (
        .clk(clk),
        .srst(srst),
        .async_in(lsosc_clk),
        .tick(tick)
    );

    always_comb
    begin
        case (cfg_ff.overflow_select)
            3'h0: exp_sel = WWDT_EXP_0;
            3'h1: exp_sel = WWDT_EXP_1;
            3'h2: exp_sel = WWDT_EXP_2;
            3'h3: exp_sel = WWDT_EXP_3;
            3'h4: exp_sel = WWDT_EXP_4;
            3'h5: exp_sel = WWDT_EXP_5;
            3'h6: exp_sel = WWDT_EXP_6;
            default: exp_sel = WWDT_EXP_7;
        endcase
    end

    // Periods are powers of two from 2^7, so quarters are exact
    assign period_m1 = (WWDT_CNT_ONE << exp_sel) - WWDT_CNT_ONE;
    assign quarter = WWDT_CNT_ONE << (exp_sel - WWDT_QUARTER_SHIFT);

    always_comb
    begin
        case ({cfg_ff.window_select_hi, cfg_ff.window_select_lo})
            2'h0: closed_lim = 18'(quarter * 18'h0_0003);
            2'h1: closed_lim = 18'(quarter << 1);
            2'h2: closed_lim = quarter;
            default: closed_lim = WWDT_CNT_ZERO;
        endcase
    end

    assign running = (state_ff == WWDT_ST_RUN);
    assign closed = (cnt_ff < closed_lim);
    assign kick_wr = running && bus_req.wr && (bus_req.addr == WWDT_KICK_ADDR);
    assign kick_bad = kick_wr && (bus_req.bitop
        || (bus_req.wdata != WWDT_SERVICE_CODE)
        || (closed && first_done_ff));
    assign kick_ok = kick_wr && !kick_bad;

    assign outside = !((bus_req.addr <= memory_size_select.rom_top)
        || (bus_req.addr >= memory_size_select.ram_base));
    assign fetch_bad = running && bus_req.fetch && outside;
    assign data_bad = running && (bus_req.rd || bus_req.wr) && outside
        && (bus_req.addr < WWDT_EXEMPT_LO);

    assign overflow = running && tick && (cnt_ff == period_m1) && !kick_ok;
    // Kick faults are only acted on at an oscillator edge, so a stopped
    // oscillator holds them back instead of losing them
    assign fault = overflow || fetch_bad || data_bad
        || (running && tick && (kick_bad || kick_pend_ff));

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cfg = cfg_ff;
        nxt_cnt = cnt_ff;
        nxt_first_done = first_done_ff;
        nxt_kick_pend = kick_pend_ff;
        nxt_kick_val = kick_val_ff;
        nxt_rst = 1'b0;
        case (state_ff)
            WWDT_ST_LOAD:
            begin
                // Option byte is caught one edge after the release
                nxt_cfg.enable = option_byte[WWDT_OPT_EN_BIT];
                nxt_cfg.window_select_hi = option_byte[WWDT_OPT_WIN_HI];
                nxt_cfg.window_select_lo = option_byte[WWDT_OPT_WIN_LO];
                nxt_cfg.overflow_select = option_byte[WWDT_OPT_OVF_HI:WWDT_OPT_OVF_LO];
                nxt_kick_val = option_byte[WWDT_OPT_EN_BIT] ?
                    WWDT_KICK_RST_ON : WWDT_KICK_RST_OFF;
                nxt_cnt = WWDT_CNT_ZERO;
                nxt_first_done = 1'b0;
                nxt_kick_pend = 1'b0;
                nxt_state = option_byte[WWDT_OPT_EN_BIT] ?
                    WWDT_ST_RUN : WWDT_ST_OFF;
            end
            WWDT_ST_RUN:
            begin
                if (fault)
                begin
                    // Restart from scratch, like a reset release
                    nxt_rst = 1'b1;
                    nxt_state = WWDT_ST_LOAD;
                    nxt_cnt = WWDT_CNT_ZERO;
                    nxt_first_done = 1'b0;
                    nxt_kick_pend = 1'b0;
                end
                else if (kick_ok)
                begin
                    nxt_cnt = WWDT_CNT_ZERO;
                    nxt_first_done = 1'b1;
                end
                else
                begin
                    if (kick_bad)
                    begin
                        nxt_kick_pend = 1'b1;
                    end
                    if (tick)
                    begin
                        nxt_cnt = cnt_ff + WWDT_CNT_ONE;
                    end
                end
            end
            WWDT_ST_OFF:
            begin
                nxt_state = WWDT_ST_OFF;
            end
            default:
            begin
                nxt_state = WWDT_ST_LOAD;
            end
        endcase
    end

    always_comb
    begin
        // Set wins over a clear in the same cycle
        nxt_cause = fault ? 1'b1 : (cause_clear ? 1'b0 : cause_ff);
        // Written code is never stored; reads show the fixed value
        nxt_rdata = (bus_req.rd && (bus_req.addr == WWDT_KICK_ADDR)) ?
            kick_val_ff : WWDT_RDATA_RST;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff <= WWDT_ST_LOAD;
            cfg_ff <= WWDT_CFG_RST;
            cnt_ff <= WWDT_CNT_ZERO;
            first_done_ff <= 1'b0;
            kick_pend_ff <= 1'b0;
            kick_val_ff <= WWDT_KICK_RST_OFF;
            rst_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cfg_ff <= nxt_cfg;
            cnt_ff <= nxt_cnt;
            first_done_ff <= nxt_first_done;
            kick_pend_ff <= nxt_kick_pend;
            kick_val_ff <= nxt_kick_val;
            rst_ff <= nxt_rst;
        end
    end

    // Cause flag is cleared only by srst or software, never by its own reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cause_ff <= 1'b0;
            rdata_ff <= WWDT_RDATA_RST;
        end
        else
        begin
            cause_ff <= nxt_cause;
            rdata_ff <= nxt_rdata;
        end
    end

    assign internal_reset = rst_ff;
    assign watchdog_cause_flag = cause_ff;
    always_comb
    begin
        reset_cause_register = WWDT_CAUSE_RST;
        reset_cause_register[WWDT_CAUSE_BIT] = cause_ff;
    end
    assign bus_rdata = rdata_ff;
    assign counting = running;
    assign window_open = running && (!closed || !first_done_ff);
    assign count_value = cnt_ff;

    a_overflow_reset: assert property (@(posedge clk) disable iff (srst)
        (running && tick && (cnt_ff == period_m1) && !kick_ok) |=> internal_reset)
        else $error("overflow did not raise internal reset");

    a_bitop_kick: assert property (@(posedge clk) disable iff (srst)
        (kick_wr && bus_req.bitop) |=> (internal_reset || kick_pend_ff))
        else $error("bit-level kick access not treated as fault");

    a_badcode_kick: assert property (@(posedge clk) disable iff (srst)
        (kick_wr && (bus_req.wdata != WWDT_SERVICE_CODE)) |=> (internal_reset || kick_pend_ff))
        else $error("wrong kick code not treated as fault");

    a_kick_clears: assert property (@(posedge clk) disable iff (srst)
        (kick_ok && !fault) |=> ((cnt_ff == WWDT_CNT_ZERO) && first_done_ff && running))
        else $error("service code did not clear the counter");

    a_closed_window: assert property (@(posedge clk) disable iff (srst)
        (kick_wr && closed && first_done_ff) |=> (internal_reset || kick_pend_ff))
        else $error("kick in closed window not treated as fault");

    a_first_kick: assert property (@(posedge clk) disable iff (srst)
        (kick_wr && !first_done_ff && !bus_req.bitop && (bus_req.wdata == WWDT_SERVICE_CODE)
        && !fetch_bad && !data_bad && !(tick && kick_pend_ff)) |=> !internal_reset)
        else $error("first kick wrongly faulted by the window");

    a_fetch_check: assert property (@(posedge clk) disable iff (srst)
        (running && bus_req.fetch && outside) |=> internal_reset)
        else $error("fetch outside enabled area not caught");

    a_data_check: assert property (@(posedge clk) disable iff (srst)
        (running && bus_req.rd && outside && (bus_req.addr < WWDT_EXEMPT_LO)) |=> internal_reset)
        else $error("data access outside enabled area not caught");

    a_cause_flag: assert property (@(posedge clk) disable iff (srst)
        internal_reset |-> (watchdog_cause_flag && reset_cause_register[WWDT_CAUSE_BIT]))
        else $error("cause flag not set with watchdog reset");

    a_read_value: assert property (@(posedge clk) disable iff (srst)
        (bus_req.rd && (bus_req.addr == WWDT_KICK_ADDR) && !running && state_ff == WWDT_ST_OFF)
        |=> (bus_rdata == WWDT_KICK_RST_OFF))
        else $error("kick register read value wrong while disabled");

    a_deferred_fault: assert property (@(posedge clk) disable iff (srst)
        (running && kick_pend_ff && !tick && !fetch_bad && !data_bad) |=> (!internal_reset && kick_pend_ff))
        else $error("kick fault not held until an oscillator edge");

    a_restart_state: assert property (@(posedge clk) disable iff (srst)
        internal_reset |-> ((state_ff == WWDT_ST_LOAD) && (cnt_ff == WWDT_CNT_ZERO) && !first_done_ff)
        ##1 !internal_reset)
        else $error("watchdog did not restart after its reset");

    a_disabled_idle: assert property (@(posedge clk) disable iff (srst)
        (state_ff == WWDT_ST_OFF) |=> ((cnt_ff == $past(cnt_ff)) && !internal_reset && !counting))
        else $error("disabled watchdog counted or reset");

endmodule // wwdt_top

// ### dv/tb.sv
// Self-checking bench for the windowed watchdog top level, driven through the CPU access port.
// Assumes wwdt_pkg is compiled first; the bench makes the low-speed clock from clk.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wwdt_pkg::*;

    // One low-speed tick is TICK clk cycles; fast enough to keep overflow runs short
    localparam int OSC_HALF = 5;
    localparam int TICK = 2 * OSC_HALF;
    localparam logic [3:0] WR = 4'h8;
    localparam logic [3:0] RD = 4'h4;
    localparam logic [3:0] FE = 4'h2;
    localparam logic [3:0] BIT = 4'h9;

    logic clk;
    logic srst;
    logic lsosc_clk = 1'b0;
    logic [7:0] option_byte;
    wwdt_bus_req_type bus_req;
    logic [7:0] bus_rdata;
    wwdt_mem_map_type memory_size_select;
    logic internal_reset;
    logic cause_clear;
    logic watchdog_cause_flag;
    logic [7:0] reset_cause_register;
    logic counting;
    logic window_open;
    logic [WWDT_CNT_W-1:0] count_value;
    logic osc_run;
    int osc_div = 0;
    int mismatches;
    int check_count;
    int n;
    int closed;

    wwdt_top DUT (
        .clk(clk),
        .srst(srst),
        .lsosc_clk(lsosc_clk),
        .option_byte(option_byte),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .memory_size_select(memory_size_select),
        .internal_reset(internal_reset),
        .cause_clear(cause_clear),
        .watchdog_cause_flag(watchdog_cause_flag),
        .reset_cause_register(reset_cause_register),
        .counting(counting),
        .window_open(window_open),
        .count_value(count_value)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Holding the level while stopped mimics an oscillator that has halted
    always @(posedge clk)
    begin
        if (osc_run)
        begin
            osc_div <= (osc_div == OSC_HALF - 1) ? 0 : osc_div + 1;
            if (osc_div == OSC_HALF - 1)
                lsosc_clk <= ~lsosc_clk;
        end
    end

    function automatic logic [7:0] opt(input logic [1:0] w, input logic e, input logic [2:0] o);
        return {1'b0, w, e, o, 1'b0};
    endfunction

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic do_reset(input logic [7:0] o);
        @(posedge clk);
        srst <= 1'b1;
        option_byte <= o;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // One access held for one cycle; returns just after the edge that answers it
    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic [3:0] k);
        @(posedge clk);
        bus_req <= '{a, d, k[3], k[2], k[1], k[0]};
        @(posedge clk);
        bus_req <= '0;
        #1;
    endtask

    task automatic wait_rst(input int lim, output int cnt);
        cnt = 0;
        while (internal_reset !== 1'b1 && cnt <= lim)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wait_cnt(input int v);
        int k;
        k = 0;
        while (count_value !== 18'(v) && k < 20000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        check(k < 20000, 1'b1);
    endtask

    initial
    begin
        srst = 1'b1;
        option_byte = 8'h00;
        bus_req = '0;
        cause_clear = 1'b0;
        osc_run = 1'b1;
        memory_size_select = '{16'h3FFF, 16'hFC00};
        mismatches = 0;
        check_count = 0;

        // Disabled: no counting, no checks, read value 1A
        do_reset(opt(2'd3, 1'b0, 3'd0));
        check(counting, 1'b0);
        access(WWDT_KICK_ADDR, 8'h55, WR);
        access(WWDT_KICK_ADDR, 8'h00, RD);
        check(bus_rdata, WWDT_KICK_RST_OFF);
        access(16'h8000, 8'h00, FE);
        wait_rst(3 * TICK, n);
        check(n > 3 * TICK, 1'b1);
        $display("test disabled done");

        // Enabled: read value 9A, kick clears the count and counting resumes
        do_reset(opt(2'd3, 1'b1, 3'd0));
        check(counting, 1'b1);
        access(WWDT_KICK_ADDR, 8'h00, RD);
        check(bus_rdata, WWDT_KICK_RST_ON);
        repeat (5 * TICK) @(posedge clk);
        access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, WR);
        check(count_value, WWDT_CNT_ZERO);
        access(WWDT_KICK_ADDR, 8'h00, RD);
        check(bus_rdata, WWDT_KICK_RST_ON);
        repeat (3 * TICK) @(posedge clk);
        #1;
        check(count_value != WWDT_CNT_ZERO, 1'b1);
        $display("test kick done");

        // Overflow period for each short select code
        for (int c = 0; c < 4; c++)
        begin
            do_reset(opt(2'd3, 1'b1, 3'(c)));
            wait_rst(20000, n);
            check(n >= (TICK << (7 + c)) - 3 * TICK, 1'b1);
            check(n <= (TICK << (7 + c)) + 3 * TICK, 1'b1);
            check(reset_cause_register, 8'h10);
        end
        @(posedge clk);
        cause_clear <= 1'b1;
        @(posedge clk);
        cause_clear <= 1'b0;
        #1;
        check(watchdog_cause_flag, 1'b0);
        $display("test overflow done");

        // Illegal kicks; each restart also proves the first kick is free again
        do_reset(opt(2'd0, 1'b1, 3'd1));
        for (int t = 0; t < 3; t++)
        begin
            access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, WR);
            wait_rst(3 * TICK, n);
            check(n > 3 * TICK, 1'b1);
            if (t == 0)
                access(WWDT_KICK_ADDR, 8'h55, WR);
            else if (t == 1)
                access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, BIT);
            else
                access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, WR);
            wait_rst(3 * TICK, n);
            check(n <= 3 * TICK, 1'b1);
            check(watchdog_cause_flag, 1'b1);
        end
        $display("test illegal kick done");

        // Window edges for open 25, 50 and 75 percent of a 256-tick period
        for (int w = 0; w < 3; w++)
        begin
            closed = (256 * (3 - w)) / 4;
            do_reset(opt(2'(w), 1'b1, 3'd1));
            access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, WR);
            wait_cnt(closed - 2);
            check(window_open, 1'b0);
            access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, WR);
            wait_rst(3 * TICK, n);
            check(n <= 3 * TICK, 1'b1);
            access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, WR);
            wait_cnt(closed + 1);
            check(window_open, 1'b1);
            access(WWDT_KICK_ADDR, WWDT_SERVICE_CODE, WR);
            check(count_value, WWDT_CNT_ZERO);
            wait_rst(3 * TICK, n);
            check(n > 3 * TICK, 1'b1);
        end
        $display("test window done");

        // Address checks; answer is due one cycle after the access
        do_reset(opt(2'd3, 1'b1, 3'd3));
        access(16'h1000, 8'h00, FE);
        check(internal_reset, 1'b0);
        access(16'hFB00, 8'h00, RD);
        check(internal_reset, 1'b0);
        access(16'h8000, 8'h00, RD);
        check(internal_reset, 1'b1);
        wait_rst(0, n);
        access(16'h8000, 8'h00, FE);
        check(internal_reset, 1'b1);
        check(watchdog_cause_flag, 1'b1);
        $display("test address done");

        // Stopped oscillator holds back a kick fault until it runs again
        do_reset(opt(2'd3, 1'b1, 3'd3));
        @(posedge clk);
        osc_run <= 1'b0;
        repeat (4) @(posedge clk);
        access(WWDT_KICK_ADDR, 8'h00, WR);
        wait_rst(10 * TICK, n);
        check(n > 10 * TICK, 1'b1);
        @(posedge clk);
        osc_run <= 1'b1;
        wait_rst(3 * TICK, n);
        check(n <= 3 * TICK, 1'b1);
        $display("test stopped clock done");
        finish_test();
    end

    initial
    begin
        #(8 * 80000);
        mismatches++;
        finish_test();
    end
endmodule // tb
